// ===== design/aof_pipeline.sv
// Contract
// - format select is a static input; the board holds it at one level
// - select high: offset binary, zero at 2048, full scale 4095
// - select low: two's complement, 0x7ff positive, 0x800 negative full scale
// - an unconnected select has no pull to low; a floating select leaves the word msb undefined
// - a sample appears at the output ten edges after capture while the pipeline advances every edge; a word that waits in the spare entry takes eleven or more
// - output word changes only just after a rising clock edge
// - spur reduction enable high turns threshold dither on
// - spur reduction enable low turns threshold dither off
// - with dither on, code thresholds may move from cycle to cycle
// - enable strapped high, as in the legacy pinout, means dither on
// - an overdriven input saturates; output words stay valid
`timescale 1ns/1ns
`default_nettype none

module aof_pipeline #(
  parameter int PIPE_STAGES = aof_pkg::PIPE_DEPTH
) (
  input wire logic clock, // sample clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clkEn, // low freezes all state
  input wire logic signed [aof_pkg::IN_W-1:0] analogInputDiff, // fine level
  input wire logic sampleValid, // level present this edge
  output logic sampleReady, // pipeline accepts a sample
  input wire logic output_format_select, // 1 offset binary, 0 two's comp
  input wire logic spur_reduction_enable, // 1 dither thresholds
  output logic [aof_pkg::CODE_W-1:0] dataOut, // output word
  output logic dataValid, // dataOut holds a word
  input wire logic sinkReady // capture logic takes the word
);
  import aof_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (PIPE_STAGES < 2) begin : g_bad_depth
      $error("PIPE_STAGES must be at least 2");
    end
  endgenerate

  // ****************************************
  // coding helper
  // ****************************************
  // offset binary in, selected coding out; only the msb differs
  function automatic logic [CODE_W-1:0] toFormat(
    input logic [CODE_W-1:0] offCode,
    input logic fmtSel
  );
    logic msb;
    msb = (fmtSel == FMT_OFFSET_BIN) ? offCode[CODE_MSB] :
      ~offCode[CODE_MSB];
    return {msb, offCode[CODE_MSB-1:0]};
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [LFSR_W-1:0] lfsr_ff;
  logic [CODE_W-1:0] stageWord_ff [PIPE_STAGES];
  logic stageValid_ff [PIPE_STAGES];
  logic [CODE_W-1:0] head_ff;
  logic headValid_ff;
  logic [CODE_W-1:0] spare_ff;
  logic spareValid_ff;
  logic sampleReady_ff;

  // ****************************************
  // threshold dither
  // ****************************************
  wire ditherOn = spur_reduction_enable;
  wire [LFSR_W-1:0] lfsrShift = {1'b0, lfsr_ff[LFSR_W-1:1]};
  wire [LFSR_W-1:0] lfsrFeed = lfsr_ff[0] ? LFSR_TAPS : {LFSR_W{1'b0}};
  wire [LFSR_W-1:0] nxt_lfsr = ditherOn ? (lfsrShift ^ lfsrFeed) : lfsr_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfsr_ff <= LFSR_SEED;
    end else if (clkEn) begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  // rounding point moves each cycle while dither is on
  wire [FRAC_W-1:0] roundOffs = ditherOn ? lfsr_ff[FRAC_W-1:0] :
    ROUND_HALF;

  // ****************************************
  // quantiser and saturation
  // ****************************************
  wire signed [IN_W:0] roundSum = $signed({analogInputDiff[IN_W-1],
    analogInputDiff}) + $signed({1'b0, {CODE_W{1'b0}}, roundOffs});
  wire signed [CODE_W:0] quant = roundSum[IN_W:FRAC_W];
  wire overHi = quant > SAT_HI;
  wire overLo = quant < SAT_LO;
  // overdrive saturates instead of wrapping
  wire [CODE_W-1:0] twosCode = overHi ? SAT_HI[CODE_W-1:0] :
    overLo ? SAT_LO[CODE_W-1:0] : quant[CODE_W-1:0];
  wire [CODE_W-1:0] offCode = {~twosCode[CODE_MSB],
    twosCode[CODE_MSB-1:0]};
  // select low is two's complement; a floating select is not read as low and leaves the msb undefined
  wire [CODE_W-1:0] codeWord = toFormat(offCode,
    output_format_select);

  // ****************************************
  // sample pipeline
  // ****************************************
  wire advance = sampleReady_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stageWord_ff[0] <= WORD_RST;
      stageValid_ff[0] <= 1'b0;
    end else if (clkEn && advance) begin
      stageWord_ff[0] <= codeWord;
      stageValid_ff[0] <= sampleValid;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < PIPE_STAGES; gi++) begin : g_stage
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          stageWord_ff[gi] <= WORD_RST;
          stageValid_ff[gi] <= 1'b0;
        end else if (clkEn && advance) begin
          stageWord_ff[gi] <= stageWord_ff[gi-1];
          stageValid_ff[gi] <= stageValid_ff[gi-1];
        end
      end

      // each hop checked where it is built
      a_pipe_latency: assert property (
        @(posedge clock) disable iff (sys_rst)
        clkEn && advance |=> stageWord_ff[gi] == $past(stageWord_ff[gi-1])
          && stageValid_ff[gi] == $past(stageValid_ff[gi-1])
      ) else $error("pipeline stage skipped or held");
    end
  endgenerate

  // capture edge plus stage hops, head load makes the last edge
  wire [CODE_W-1:0] lastWord = stageWord_ff[PIPE_STAGES-1];
  wire lastValid = stageValid_ff[PIPE_STAGES-1];

  // ****************************************
  // two-entry output buffer
  // ****************************************
  // the head register is separate and loads from the last pipeline stage one edge later
  wire push = advance && lastValid;
  wire pop = headValid_ff && sinkReady;
  wire headFree = !headValid_ff || pop;
  wire [1:0] fill = {1'b0, headValid_ff} + {1'b0, spareValid_ff};
  wire [1:0] nxt_fill = fill + {1'b0, push} - {1'b0, pop};
  // registered ready drops on the edge the buffer fills
  wire nxt_sampleReady = nxt_fill != 2'h2;

  wire [CODE_W-1:0] nxt_head = !headFree ? head_ff :
    spareValid_ff ? spare_ff : lastWord;
  wire nxt_headValid = !headFree || spareValid_ff || push;
  wire nxt_spareValid = headFree ? (spareValid_ff && push) :
    (spareValid_ff || push);
  wire spareLoad = push && (spareValid_ff || !headFree);
  wire [CODE_W-1:0] nxt_spare = spareLoad ? lastWord : spare_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      head_ff <= WORD_RST;
      headValid_ff <= 1'b0;
      spare_ff <= WORD_RST;
      spareValid_ff <= 1'b0;
      sampleReady_ff <= READY_RST;
    end else if (clkEn) begin
      head_ff <= nxt_head;
      headValid_ff <= nxt_headValid;
      spare_ff <= nxt_spare;
      spareValid_ff <= nxt_spareValid;
      sampleReady_ff <= nxt_sampleReady;
    end
  end

  assign dataOut = head_ff;
  assign dataValid = headValid_ff;
  assign sampleReady = sampleReady_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_stage_format: assert property (
    clkEn && advance && output_format_select
    |=> stageWord_ff[0] == $past(offCode)
  ) else $error("offset binary word does not match level");

  a_twos_format: assert property (
    clkEn && advance && !output_format_select
    |=> stageWord_ff[0] == $past(twosCode)
  ) else $error("two's complement word does not match level");

  a_msb_only: assert property (
    clkEn && advance
    |=> stageWord_ff[0][CODE_MSB-1:0] == $past(offCode[CODE_MSB-1:0])
  ) else $error("codings differ below the msb");

  a_clamp_high: assert property (
    clkEn && advance && output_format_select &&
      analogInputDiff[IN_W-1] == 1'b0 && overHi
    |=> stageWord_ff[0] == CODE_ALL1
  ) else $error("positive overdrive not held at full scale");

  a_clamp_low: assert property (
    clkEn && advance && output_format_select &&
      analogInputDiff == {1'b1, {(IN_W-1){1'b0}}}
    |=> stageWord_ff[0] == CODE_ALL0
  ) else $error("negative overdrive not held at zero code");

  a_zero_mid: assert property (
    clkEn && advance && output_format_select && !ditherOn &&
      analogInputDiff == '0
    |=> stageWord_ff[0] == CODE_MID
  ) else $error("zero input not at midscale");

  a_twos_zero: assert property (
    clkEn && advance && !output_format_select && !ditherOn &&
      analogInputDiff == '0
    |=> stageWord_ff[0] == CODE_ALL0
  ) else $error("two's complement zero input not at zero code");

  a_twos_minus: assert property (
    clkEn && advance && !output_format_select && !ditherOn &&
      analogInputDiff == {{CODE_W{1'b1}}, {FRAC_W{1'b0}}}
    |=> stageWord_ff[0] == CODE_ALL1
  ) else $error("minus one lsb not all ones");

  a_twos_top: assert property (
    clkEn && advance && !output_format_select &&
      analogInputDiff == {1'b0, {(IN_W-1){1'b1}}}
    |=> stageWord_ff[0] == SAT_HI[CODE_W-1:0]
  ) else $error("two's complement full scale not at top code");

  a_capture_valid: assert property (
    clkEn && advance |=> stageValid_ff[0] == $past(sampleValid)
  ) else $error("capture stage valid does not follow input");

  a_dither_hold: assert property (
    clkEn && !ditherOn |=> $stable(lfsr_ff)
  ) else $error("dither moved while disabled");

  a_dither_moves: assert property (
    clkEn && ditherOn |=> lfsr_ff != $past(lfsr_ff)
  ) else $error("dither stuck while enabled");

  a_dither_round: assert property (
    !ditherOn |-> roundOffs == ROUND_HALF
  ) else $error("rounding point not fixed with dither off");

  a_no_loss: assert property (
    clkEn && dataValid && !sinkReady
    |=> dataValid && $stable(dataOut)
  ) else $error("stalled word was lost or changed");

  a_full_stall: assert property (
    headValid_ff && spareValid_ff |-> !sampleReady
  ) else $error("ready while buffer full");

  a_freeze: assert property (
    !clkEn |=> $stable(dataOut) && $stable(dataValid) &&
      $stable(sampleReady)
  ) else $error("outputs changed while clock enable low");

  a_freeze_core: assert property (
    !clkEn |=> $stable(lfsr_ff) && $stable(head_ff) && $stable(spare_ff)
  ) else $error("state changed while clock enable low");

  // ****************************************
  // buffer checks
  // ****************************************
  a_head_fill: assert property (
    clkEn && push && headFree && !spareValid_ff
    |=> dataValid && dataOut == $past(lastWord)
  ) else $error("head did not take the last stage word");

  a_spare_order: assert property (
    clkEn && headFree && spareValid_ff
    |=> dataValid && dataOut == $past(spare_ff)
  ) else $error("spare word not moved to head in order");

  a_bubble_drop: assert property (
    clkEn && headFree && !spareValid_ff && !push |=> !dataValid
  ) else $error("empty slot reached the output");

  a_no_overflow: assert property (
    clkEn && spareValid_ff && !headFree |-> !push
  ) else $error("word pushed into a full buffer");

  a_ready_back: assert property (
    clkEn && spareValid_ff && pop |=> sampleReady
  ) else $error("ready did not return after a pop");

endmodule

`default_nettype wire

// ===== design/aof_pkg.sv
`default_nettype none

// ****************************************
// output format pipeline constants
// ****************************************
package aof_pkg;

  // word layout
  localparam int CODE_W = 12;
  localparam int CODE_MSB = CODE_W - 1;
  localparam int FRAC_W = 4;
  localparam int IN_W = CODE_W + FRAC_W;

  // pipeline depth from sample edge to presented word
  localparam int PIPE_DEPTH = 10;

  // clock
  localparam int CLOCK_MHZ = 25;

  // saturation bounds, two's complement code domain
  localparam logic signed [CODE_W:0] SAT_HI = 13'sh07ff;
  localparam logic signed [CODE_W:0] SAT_LO = -13'sh0800;

  // offset binary midscale and code extremes
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] CODE_ALL1 = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ALL0 = 12'h000;

  // fixed rounding point (half an lsb) when spur reduction is off
  localparam logic [FRAC_W-1:0] ROUND_HALF = 4'h8;

  // threshold dither generator
  localparam int LFSR_W = 16;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;

  // reset values
  localparam logic [CODE_W-1:0] WORD_RST = 12'h000;
  localparam logic [1:0] FILL_RST = 2'h0;
  localparam logic READY_RST = 1'b1;

  // format select levels
  localparam logic FMT_OFFSET_BIN = 1'b1;
  localparam logic FMT_TWOS_COMP = 1'b0;

endpackage

`default_nettype wire

// ===== verification/aof_capture_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// downstream capture logic
// ****************************************
module aof_capture_model (
  input wire logic clock, // sample clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clkEn, // edge qualifier
  input wire logic [aof_pkg::CODE_W-1:0] dataOut, // word from device
  input wire logic dataValid, // word present
  output logic sinkReady, // takes the word
  input wire logic slow // ready one edge in four
);
  import aof_pkg::*;
  logic [CODE_W-1:0] words[$];
  logic [1:0] pace_ff = 2'h0;
  always @(posedge clock) begin
    if (!sys_rst && clkEn && dataValid && sinkReady) begin
      words.push_back(dataOut);
    end
    pace_ff <= pace_ff + 2'h1;
    sinkReady <= !sys_rst && (!slow || pace_ff == 2'h3);
  end
endmodule

`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import aof_pkg::*;
  logic clock, sys_rst, sampleValid, sampleReady, formatSel;
  logic spur, dataValid, sinkReady, slow, gapEn;
  logic clkEn = 1'b1;
  logic refused = 1'b0;
  logic [2:0] tick = 3'h0;
  logic signed [IN_W-1:0] analogInputDiff;
  logic [CODE_W-1:0] dataOut;
  logic [CODE_W-1:0] expq[$];
  int n_mismatch, comparisons;
  aof_pipeline #(.PIPE_STAGES(PIPE_DEPTH)) dut_u (.clock(clock),
    .sys_rst(sys_rst), .clkEn(clkEn), .analogInputDiff(analogInputDiff),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .output_format_select(formatSel), .spur_reduction_enable(spur),
    .dataOut(dataOut), .dataValid(dataValid), .sinkReady(sinkReady));
  aof_capture_model cap_u (.clock(clock), .sys_rst(sys_rst),
    .clkEn(clkEn), .dataOut(dataOut), .dataValid(dataValid),
    .sinkReady(sinkReady), .slow(slow));
  // ****************************************
  // clock, enable gaps, refusal monitor
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    tick <= tick + 3'h1;
    clkEn <= !gapEn || tick != 3'h4;
    if (!sys_rst && sampleReady === 1'b0) refused <= 1'b1;
  end
  // ****************************************
  // compare and helpers
  // ****************************************
  task automatic check_word(string s, logic [CODE_W-1:0] e,
                            logic [CODE_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic check_int(string s, int e, int g);
    comparisons++;
    if (g != e) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", s, e, g);
    end
  endtask
  function automatic logic [CODE_W-1:0] code_of(int lv, logic ob);
    int t;
    t = (lv + 8) >>> 4;
    if (t > 2047) t = 2047;
    if (t < -2048) t = -2048;
    return {t[CODE_MSB] ^ ob, t[CODE_MSB-1:0]};
  endfunction
  task automatic stream(int lv[$], logic ob);
    int i;
    i = 0;
    cap_u.words.delete();
    expq.delete();
    formatSel <= ob;
    @(posedge clock);
    while (i < lv.size()) begin
      analogInputDiff <= lv[i][IN_W-1:0];
      sampleValid <= 1'b1;
      @(posedge clock);
      if (clkEn && sampleReady) begin
        if (!spur) expq.push_back(code_of(lv[i], ob));
        i++;
      end
    end
    sampleValid <= 1'b0;
  endtask
  task automatic drain(string s, int cnt);
    int n;
    n = 0;
    while (cap_u.words.size() < cnt && n < 600) begin
      @(posedge clock);
      n++;
    end
    check_int({s, " count"}, cnt, cap_u.words.size());
    foreach (expq[k]) if (k < cap_u.words.size())
      check_word(s, expq[k], cap_u.words[k]);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_latency();
    int n;
    n = 0;
    @(posedge clock);
    analogInputDiff <= 16'sh0100;
    sampleValid <= 1'b1;
    @(posedge clock);
    sampleValid <= 1'b0;
    while (n < 30 && dataValid !== 1'b1) begin
      @(posedge clock);
      n++;
      #1;
    end
    check_int("latency", PIPE_DEPTH, n);
    check_word("first word", code_of(256, 1'b0), dataOut);
    repeat (2) @(posedge clock);
  endtask
  task automatic t_coding();
    int lv[$];
    lv = '{0, 7, 8, -16, 32752, 32767, -32768, -32760};
    stream(lv, 1'b1);
    drain("offset code", 8);
    stream(lv, 1'b0);
    drain("twos code", 8);
  endtask
  task automatic t_stall();
    int lv[$];
    for (int i = 0; i < 40; i++) lv.push_back(i * 16 - 320);
    slow <= 1'b1;
    gapEn <= 1'b1;
    stream(lv, 1'b1);
    drain("stalled word", 40);
    check_int("refusal seen", 1, refused === 1'b1);
    slow <= 1'b0;
    gapEn <= 1'b0;
  endtask
  task automatic t_dither();
    int lv[$];
    int ones, zeros;
    ones = 0;
    zeros = 0;
    repeat (48) lv.push_back(8);
    spur <= 1'b1;
    stream(lv, 1'b0);
    drain("dither", 48);
    foreach (cap_u.words[k]) begin
      ones += (cap_u.words[k] === 12'h001);
      zeros += (cap_u.words[k] === 12'h000);
    end
    check_int("dither spread", 1, ones > 0 && zeros > 0);
    check_int("dither codes", 48, ones + zeros);
    spur <= 1'b0;
    stream(lv, 1'b0);
    drain("steady", 48);
  endtask
  task automatic conclude();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {sampleValid, formatSel, spur, slow, gapEn} = 5'h00;
    analogInputDiff = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check_word("valid after reset", 12'h000, {11'h0, dataValid});
    check_word("ready after reset", 12'h001, {11'h0, sampleReady});
    t_latency();
    t_coding();
    t_stall();
    t_dither();
    conclude();
  end
endmodule

`default_nettype wire
